// *** instruction_word_decoder_tb_top.sv ***
// Self-checking testbench of the instruction word decoder fed by the fetch model.
module instruction_word_decoder_tb_top import iwd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed { logic [23:0] word; iwd_class_t cls; } iwd_row_t;

  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        redirect = 1'b0;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  len = 4'h0;
  logic [23:0] word, ext, w2;
  logic        word_valid, busy, ready, valid, is_nop, dbl, dw_err;
  logic [7:0]  opcode;
  iwd_class_t  cls;
  logic [3:0]  base_reg, bit_pos, xpf, ypf, shreg;
  logic [6:0]  src, res;
  logic [12:0] faddr;
  logic [15:0] literal;
  logic [22:0] pa;
  logic [2:0]  pair;
  logic [1:0]  awb, tmode;
  logic        res_sep, file_form, to_dflt, bit_ind, lit_arith, mac, acc, by_reg;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [7:0]  dw_opc [3] = '{8'h04, 8'h02, 8'h3e};
  iwd_row_t    rows [11] = '{'{24'h1f9234, IWD_CLS_CTRL}, '{24'h2a5a5a, IWD_CLS_WORD},
    '{24'h4c2005, IWD_CLS_WORD}, '{24'h4c0005, IWD_CLS_WORD}, '{24'h6bf00f, IWD_CLS_BIT},
    '{24'h8fedcb, IWD_CLS_LIT}, '{24'ha81234, IWD_CLS_LIT}, '{24'ha01234, IWD_CLS_LIT},
    '{24'hc7abcd, IWD_CLS_DSP}, '{24'he35678, IWD_CLS_DSP}, '{24'h000000, IWD_CLS_NOP}};

  always #2 clock = ~clock;

  iwd_fetch_model fm (.i_clock(clock), .i_rstn(rstn), .i_ready(ready), .i_start(start), .i_slow(slow),
    .i_len(len), .o_word(word), .o_word_valid(word_valid), .o_busy(busy));

  iwd_decoder dut (.i_clock(clock), .i_rstn(rstn), .i_word(word), .i_word_valid(word_valid),
    .i_redirect(redirect), .o_ready(ready), .o_valid(valid), .o_opcode(opcode), .o_class(cls),
    .o_is_nop(is_nop), .o_double(dbl), .o_dw_error(dw_err), .o_ext_word(ext), .o_base_reg(base_reg),
    .o_source_reg_operand(src), .o_result_reg_operand(res), .o_result_separate(res_sep),
    .o_file_addr(faddr), .o_file_form(file_form), .o_to_default_work_target(to_dflt),
    .o_bit_pos(bit_pos), .o_bit_indirect(bit_ind), .o_literal(literal), .o_lit_arith(lit_arith),
    .o_multiply_accumulate_class(mac), .o_accum_sel(acc), .o_mult_pair(pair), .o_x_prefetch(xpf),
    .o_y_prefetch(ypf), .o_awb(awb), .o_shift_by_reg(by_reg), .o_shift_count_reg(shreg),
    .o_prog_addr(pa), .o_table_mode(tmode));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic run(input logic [3:0] n, input logic s);
    @(posedge clock);
    len <= n;
    slow <= s;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask

  // Bounded wait, so a decoder that never issues ends as a mismatch rather than a hang.
  task automatic wait_issue();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (valid !== 1'b1 && n < 20);
    check("issue", 32'(valid), 32'h1);
  endtask

  task automatic check_row(input logic [23:0] w, input iwd_class_t c);
    logic [2:0]  g;
    logic [15:0] lit;
    g = w[23:21];
    lit = 16'h0;
    if (g == 3'h0) lit = w[15:0];
    if (g == 3'h4) lit = w[19:4];
    if (g == 3'h5) lit = {11'h0, w[4:0]};
    if (g == 3'h7) lit = {10'h0, w[9:4]};
    check("opcode", 32'(opcode), 32'(w[23:16]));
    check("class", 32'({cls, is_nop}), 32'({c, w[23:16] == 8'h00}));
    check("double", 32'({dbl, ext}), 32'h0);
    check("base", 32'({base_reg, src}), 32'({w[18:15], w[6:0]}));
    check("result", 32'(res), (g == 3'h5 && !w[19]) ? 32'(w[18:15]) : 32'(w[13:7]));
    check("separate", 32'(res_sep), 32'(g == 3'h5 && w[19]));
    check("file", 32'({file_form, to_dflt, faddr}), 32'({g == 3'h2, g == 3'h2 && !w[13], w[12:0]}));
    check("bit", 32'({bit_pos, bit_ind}), 32'({w[15:12], w[14]}));
    check("literal", 32'({lit_arith, literal}), 32'({g == 3'h5, lit}));
    check("mac", 32'({mac, acc, pair, xpf, ypf, awb}), 32'({g == 3'h6, w[15], w[14:12], w[11:4], w[1:0]}));
    check("shift", 32'({by_reg, shreg}), 32'({w[14], w[3:0]}));
    check("control", 32'({pa, tmode}), 32'({7'h0, w[15:1], 1'b0, w[15:14]}));
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    check("reset", 32'({ready, valid, cls}), 32'({2'h2, IWD_CLS_NOP}));
    rstn <= 1'b1;
    foreach (rows[i]) fm.prog[i] = rows[i].word;
    run(4'hb, 1'b0);
    foreach (rows[i]) begin
      wait_issue();
      check_row(rows[i].word, rows[i].cls);
    end
    check("fetch idle", 32'(busy), 32'h0);
    $display("Test table finished");
    // Good pairs come back to back; bad ones are fed slowly so the quiet gap is covered too.
    foreach (dw_opc[i]) begin
      for (int bad = 0; bad < 2; bad++) begin
        w2 = (bad == 1) ? 24'h120055 : 24'h000055;
        fm.prog[0] = {dw_opc[i], 16'h1234};
        fm.prog[1] = w2;
        run(4'h2, 1'(bad));
        repeat (1 + bad) begin
          @(posedge clock);
          #1;
          check("early", 32'(valid), 32'h0);
        end
        wait_issue();
        check("pair", 32'({dbl, dw_err, is_nop}), 32'({1'b1, bad == 1, 1'b0}));
        check("ext", 32'(ext), 32'(w2));
        check("paddr", 32'(pa), 32'h551234);
        @(posedge clock);
        #1;
        check("one pulse", 32'(valid), 32'h0);
      end
    end
    $display("Test pairs finished");
    fm.prog[0] = 24'h000077;
    run(4'h1, 1'b0);
    wait_issue();
    check("lone second", 32'({is_nop, dbl, cls}), 32'({2'h2, IWD_CLS_NOP}));
    $display("Test lone second word finished");
    fm.prog[0] = 24'h1f0000;
    fm.prog[1] = 24'h2a0000;
    fm.prog[2] = 24'h2b0000;
    run(4'h3, 1'b0);
    @(posedge clock);
    redirect <= 1'b1;
    #1;
    check("redirected", 32'({valid, opcode}), 32'h11f);
    @(posedge clock);
    redirect <= 1'b0;
    #1;
    check("bubble ready", 32'({ready, valid}), 32'h0);
    @(posedge clock);
    #1;
    check("bubble", 32'({ready, valid, is_nop, cls}), 32'({3'h7, IWD_CLS_NOP}));
    @(posedge clock);
    #1;
    check("after bubble", 32'({valid, opcode}), 32'h12b);
    $display("Test redirect finished");
    run(4'h3, 1'b0);
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    #1;
    check("mid reset", 32'({ready, valid, opcode}), 32'h200);
    @(posedge clock);
    rstn <= 1'b1;
    run(4'h1, 1'b0);
    wait_issue();
    check("after reset", 32'({dbl, opcode}), 32'h01f);
    $display("Test second reset finished");
    wrap_up();
  end
endmodule  // instruction_word_decoder_tb_top

// *** iwd_cycle_ctrl.sv ***
// Fetch sequencing: first and second word of a pair, and the flush cycle after a redirect.
module iwd_cycle_ctrl
  import iwd_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_word_valid,
  input  wire logic i_is_double,
  input  wire logic i_flush,
  output logic      o_ready,
  output logic      o_take_single,
  output logic      o_take_first,
  output logic      o_take_second,
  output iwd_state_t o_state
);
  iwd_state_t state_q;
  iwd_state_t state_d;

  always_comb begin
    o_ready       = (state_q != IWD_ST_BUBBLE);
    o_take_single = i_word_valid && (state_q == IWD_ST_EXEC) && !i_is_double && !i_flush;
    o_take_first  = i_word_valid && (state_q == IWD_ST_EXEC) && i_is_double && !i_flush;
    o_take_second = i_word_valid && (state_q == IWD_ST_SECOND);
    o_state       = state_q;
    state_d       = state_q;
    case (state_q)
      IWD_ST_EXEC: begin
        if (i_flush) begin
          state_d = IWD_ST_BUBBLE;
        end else if (o_take_first) begin
          state_d = IWD_ST_SECOND;
        end
      end
      IWD_ST_SECOND: begin
        if (i_word_valid) begin
          state_d = IWD_ST_EXEC;
        end
      end
      default: state_d = IWD_ST_EXEC;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= IWD_ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  AST_FIRST_WAITS_SECOND: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_take_first |=> (state_q == IWD_ST_SECOND))
    else $error("First word of a pair did not arm the second-word wait.");

  AST_BUBBLE_SINGLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == IWD_ST_BUBBLE) |-> !o_ready ##1 (state_q == IWD_ST_EXEC))
    else $error("Flush bubble did not last exactly one cycle.");
endmodule // iwd_cycle_ctrl

// *** iwd_decoder.sv ***
// Instruction word decoder: splits fetched words into opcode, class and operand fields.
// Function
// - Almost every instruction is one 24-bit program word.
// - Exactly three opcodes span two consecutive program words.
// - Upper 8 bits are the opcode; lower bits hold operand fields.
// - Each instruction falls into one of six classes.
// - Register word ops carry base, source and result register operands.
// - Memory word ops carry an address and memory-or-default-register destination.
// - Bit ops name a register or address and a literal or indirect bit.
// - Literal moves load an immediate into a register or memory address.
// - Literal arithmetic uses base and literal; separate result only if flagged.
// - Multiply-accumulate ops name accumulator, multiplicands, prefetches and write-back.
// - Other DSP ops name accumulator, operand and register or literal shift.
// - Control ops carry a program address or a table access mode.
// - A double-word instruction assembles its operands from 48 bits.
// - The second word of a pair has its top 8 bits zero.
// - A second word executed alone decodes as a no-operation.
// - A taken redirect from a single word adds one no-operation cycle.
// - Double-word instructions take two instruction cycles.
`include "iwd_defines.svh"
module iwd_decoder
  import iwd_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic [23:0] i_word,
  input  wire logic        i_word_valid,
  input  wire logic        i_redirect,
  output logic             o_ready,
  output logic             o_valid,
  output logic      [7:0]  o_opcode,
  output iwd_class_t       o_class,
  output logic             o_is_nop,
  output logic             o_double,
  output logic             o_dw_error,
  output logic      [23:0] o_ext_word,
  output logic      [3:0]  o_base_reg,
  output logic      [6:0]  o_source_reg_operand,
  output logic      [6:0]  o_result_reg_operand,
  output logic             o_result_separate,
  output logic      [12:0] o_file_addr,
  output logic             o_file_form,
  output logic             o_to_default_work_target,
  output logic      [3:0]  o_bit_pos,
  output logic             o_bit_indirect,
  output logic      [15:0] o_literal,
  output logic             o_lit_arith,
  output logic             o_multiply_accumulate_class,
  output logic             o_accum_sel,
  output logic      [2:0]  o_mult_pair,
  output logic      [3:0]  o_x_prefetch,
  output logic      [3:0]  o_y_prefetch,
  output logic      [1:0]  o_awb,
  output logic             o_shift_by_reg,
  output logic      [3:0]  o_shift_count_reg,
  output logic      [22:0] o_prog_addr,
  output logic      [1:0]  o_table_mode
);
  iwd_state_t  state;
  logic        take_single;
  logic        take_first;
  logic        take_second;
  logic        flush;
  logic [23:0] prim;
  logic [7:0]  x_opc;
  iwd_class_t  x_cls;
  logic        x_dbl;
  logic        x_file;
  logic        x_arith;
  logic        x_mac;
  logic [15:0] x_lit;
  logic        load;

  logic [23:0] first_q, first_d;
  logic        valid_q, valid_d;
  logic [7:0]  opc_q, opc_d;
  iwd_class_t  cls_q, cls_d;
  logic        nop_q, nop_d;
  logic        dbl_q, dbl_d;
  logic        err_q, err_d;
  logic [23:0] ext_q, ext_d;
  logic [23:0] word_q, word_d;
  logic        file_q, file_d;
  logic        arith_q, arith_d;
  logic        mac_q, mac_d;
  logic [15:0] lit_q, lit_d;
  logic [22:0] paddr_q, paddr_d;

  // While the second word is awaited, the held first word drives field extraction.
  assign prim  = (state == IWD_ST_SECOND) ? first_q : i_word;
  // A redirect from a paired instruction costs nothing extra: its second cycle covers it.
  assign flush = valid_q && i_redirect && !dbl_q;

  iwd_field_extract u_extract (
    .i_word      (prim),
    .o_opcode    (x_opc),
    .o_class     (x_cls),
    .o_is_double (x_dbl),
    .o_file_form (x_file),
    .o_lit_arith (x_arith),
    .o_mac       (x_mac),
    .o_literal   (x_lit)
  );

  iwd_cycle_ctrl u_ctrl (
    .i_clock       (i_clock),
    .i_rstn        (i_rstn),
    .i_word_valid  (i_word_valid),
    .i_is_double   (x_dbl),
    .i_flush       (flush),
    .o_ready       (o_ready),
    .o_take_single (take_single),
    .o_take_first  (take_first),
    .o_take_second (take_second),
    .o_state       (state)
  );

  always_comb begin
    load     = take_single || take_second;
    first_d  = take_first ? i_word : first_q;
    valid_d  = load || (state == IWD_ST_BUBBLE);
    opc_d    = opc_q;
    cls_d    = cls_q;
    nop_d    = 1'b0;
    dbl_d    = 1'b0;
    err_d    = 1'b0;
    ext_d    = ext_q;
    word_d   = word_q;
    file_d   = file_q;
    arith_d  = arith_q;
    mac_d    = mac_q;
    lit_d    = lit_q;
    paddr_d  = paddr_q;
    if (state == IWD_ST_BUBBLE) begin
      // The flushed slot is issued as an operation with no effect.
      opc_d = `IWD_OPC_NOP;
      cls_d = IWD_CLS_NOP;
      nop_d = 1'b1;
    end else if (load) begin
      opc_d   = x_opc;
      cls_d   = x_cls;
      nop_d   = (x_cls == IWD_CLS_NOP);
      word_d  = prim;
      file_d  = x_file;
      arith_d = x_arith;
      mac_d   = x_mac;
      lit_d   = x_lit;
      dbl_d   = take_second;
      ext_d   = take_second ? i_word : 24'h000000;
      // A second word that breaks the zero-prefix form is flagged on o_dw_error but still issued as a valid pair.
      err_d   = take_second && (i_word[`IWD_OPC_HI:`IWD_OPC_LO] != 8'h00);
      if (take_second) begin
        paddr_d = {i_word[6:0], prim[15:1], 1'b0};
      end else begin
        paddr_d = {7'h00, prim[15:1], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      first_q <= 24'h000000;
      valid_q <= 1'b0;
      opc_q   <= 8'h00;
      cls_q   <= IWD_CLS_NOP;
      nop_q   <= 1'b0;
      dbl_q   <= 1'b0;
      err_q   <= 1'b0;
      ext_q   <= 24'h000000;
      word_q  <= 24'h000000;
      file_q  <= 1'b0;
      arith_q <= 1'b0;
      mac_q   <= 1'b0;
      lit_q   <= 16'h0000;
      paddr_q <= 23'h000000;
    end else begin
      first_q <= first_d;
      valid_q <= valid_d;
      opc_q   <= opc_d;
      cls_q   <= cls_d;
      nop_q   <= nop_d;
      dbl_q   <= dbl_d;
      err_q   <= err_d;
      ext_q   <= ext_d;
      word_q  <= word_d;
      file_q  <= file_d;
      arith_q <= arith_d;
      mac_q   <= mac_d;
      lit_q   <= lit_d;
      paddr_q <= paddr_d;
    end
  end

  // Fields other than result register, literal, program address and the file, arithmetic, MAC, result-separate and default-target flags are slices of word_q.
  assign o_valid                     = valid_q;
  assign o_opcode                    = opc_q;
  assign o_class                     = cls_q;
  assign o_is_nop                    = nop_q;
  assign o_double                    = dbl_q;
  assign o_dw_error                  = err_q;
  assign o_ext_word                  = ext_q;
  assign o_base_reg                  = word_q[`IWD_BASE_HI:`IWD_BASE_LO];
  assign o_source_reg_operand        = word_q[`IWD_SRC_HI:`IWD_SRC_LO];
  assign o_result_reg_operand        = (arith_q && !word_q[`IWD_RES_SEP_BIT]) ?
                                       {3'h0, word_q[`IWD_BASE_HI:`IWD_BASE_LO]} :
                                       word_q[`IWD_RES_HI:`IWD_RES_LO];
  assign o_result_separate           = arith_q && word_q[`IWD_RES_SEP_BIT];
  assign o_file_addr                 = word_q[`IWD_FADDR_HI:`IWD_FADDR_LO];
  assign o_file_form                 = file_q;
  assign o_to_default_work_target    = file_q && !word_q[`IWD_TO_DFLT_BIT];
  assign o_bit_pos                   = word_q[`IWD_BITPOS_HI:`IWD_BITPOS_LO];
  assign o_bit_indirect              = word_q[`IWD_BIT_IND_BIT];
  assign o_literal                   = lit_q;
  assign o_lit_arith                 = arith_q;
  assign o_multiply_accumulate_class = mac_q;
  assign o_accum_sel                 = word_q[`IWD_ACC_BIT];
  assign o_mult_pair                 = word_q[14:12];
  assign o_x_prefetch                = word_q[11:8];
  assign o_y_prefetch                = word_q[7:4];
  assign o_awb                       = word_q[1:0];
  assign o_shift_by_reg              = word_q[`IWD_SHIFT_REG_BIT];
  assign o_shift_count_reg           = word_q[3:0];
  assign o_prog_addr                 = paddr_q;
  assign o_table_mode                = word_q[15:14];

  sequence seq_pair_taken;
    take_first ##1 take_second;
  endsequence

  sequence seq_pair_issued;
    valid_q && dbl_q && !nop_q;
  endsequence

  AST_PAIR_ISSUE: assert property (@(posedge i_clock) disable iff (!i_rstn)
    seq_pair_taken |=> seq_pair_issued)
    else $error("Paired instruction was not issued after its second word.");

  AST_NO_ISSUE_ON_FIRST: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_first |=> !valid_q)
    else $error("First word of a pair issued before its second word arrived.");

  AST_SINGLE_ONE_CYCLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_single |=> valid_q && !dbl_q)
    else $error("Single word not issued in the next cycle.");

  AST_OPCODE_FIELD: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_single |=> (opc_q == $past(i_word[23:16])))
    else $error("Opcode does not match the upper eight bits.");

  AST_BIT_CLASS: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_single && (i_word[23:21] == 3'h3) |=> (cls_q == IWD_CLS_BIT))
    else $error("Bit group opcode not classified as bit class.");

  AST_LONE_SECOND_NOP: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_single && (i_word[23:16] == 8'h00) |=> nop_q && valid_q)
    else $error("Lone zero-prefixed word did not issue as no-operation.");

  AST_EXT_PREFIX: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_second && (i_word[`IWD_OPC_HI:`IWD_OPC_LO] != 8'h00) |=> o_dw_error && o_valid && o_double)
    else $error("Second word with a nonzero prefix was not flagged.");

  AST_REDIRECT_BUBBLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
    flush |=> !o_ready ##1 (valid_q && nop_q && o_ready))
    else $error("Redirect did not yield exactly one no-operation slot.");

  AST_PADDR_JOIN: assert property (@(posedge i_clock) disable iff (!i_rstn)
    take_second |=> (paddr_q[22:16] == $past(i_word[6:0])) && !paddr_q[0])
    else $error("Program address not assembled from both words.");
endmodule // iwd_decoder

// *** iwd_defines.svh ***
// Bit positions, opcode values and cycle figures of the instruction word decoder.
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

`define IWD_WORD_W        24
`define IWD_OPC_HI        23
`define IWD_OPC_LO        16
`define IWD_GRP_HI        23
`define IWD_GRP_LO        21
`define IWD_OPC_NOP       8'h00
`define IWD_OPC_DW_GOTO   8'h04
`define IWD_OPC_DW_CALL   8'h02
`define IWD_OPC_DW_MOVD   8'h3e
`define IWD_DW_COUNT      3
`define IWD_BASE_HI       18
`define IWD_BASE_LO       15
`define IWD_SRC_HI        6
`define IWD_SRC_LO        0
`define IWD_RES_HI        13
`define IWD_RES_LO        7
`define IWD_FADDR_HI      12
`define IWD_FADDR_LO      0
`define IWD_TO_DFLT_BIT   13
`define IWD_BITPOS_HI     15
`define IWD_BITPOS_LO     12
`define IWD_BIT_IND_BIT   14
`define IWD_RES_SEP_BIT   19
`define IWD_ACC_BIT       15
`define IWD_SHIFT_REG_BIT 14
`define IWD_CYC_SINGLE    1
`define IWD_CYC_DOUBLE    2

`endif

// *** iwd_fetch_model.sv ***
// Program memory fetch model that hands words to the decoder and honours its ready.
module iwd_fetch_model (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_ready,
  input  wire logic        i_start,
  input  wire logic        i_slow,
  input  wire logic [3:0]  i_len,
  output logic      [23:0] o_word,
  output logic             o_word_valid,
  output logic             o_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [23:0] prog [16];
  logic [3:0]  ptr;
  logic        gap;

  initial begin
    o_word = 24'h0;
    o_word_valid = 1'b0;
    o_busy = 1'b0;
  end

  // Between words the bus shows the inverted last word, so a stale value is never taken for data.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_word_valid <= 1'b0;
      o_busy <= 1'b0;
      gap <= 1'b0;
      ptr <= 4'h0;
    end else if (i_start) begin
      o_word <= prog[0];
      o_word_valid <= 1'b1;
      o_busy <= 1'b1;
      ptr <= 4'h0;
    end else if (gap) begin
      o_word <= prog[ptr];
      o_word_valid <= 1'b1;
      gap <= 1'b0;
    end else if (o_word_valid && i_ready) begin
      ptr <= ptr + 4'h1;
      if (ptr + 4'h1 == i_len || i_slow) begin
        o_word <= ~o_word;
        o_word_valid <= 1'b0;
        gap <= (ptr + 4'h1 != i_len);
        o_busy <= (ptr + 4'h1 != i_len);
      end else begin
        o_word <= prog[ptr + 4'h1];
      end
    end
  end
endmodule  // iwd_fetch_model

// *** iwd_field_extract.sv ***
// Combinational split of one 24-bit word into opcode, class and operand fields.
`include "iwd_defines.svh"
module iwd_field_extract
  import iwd_pkg::*;
(
  input  wire logic [23:0] i_word,
  output logic      [7:0]  o_opcode,
  output iwd_class_t       o_class,
  output logic             o_is_double,
  output logic             o_file_form,
  output logic             o_lit_arith,
  output logic             o_mac,
  output logic      [15:0] o_literal
);
  logic [2:0] grp;

  always_comb begin
    grp         = i_word[`IWD_GRP_HI:`IWD_GRP_LO];
    o_opcode    = i_word[`IWD_OPC_HI:`IWD_OPC_LO];
    o_class     = iwd_classify(o_opcode);
    o_is_double = iwd_is_double(o_opcode);
    o_file_form = (grp == 3'h2);
    o_lit_arith = (grp == 3'h5);
    o_mac       = (grp == 3'h6);
    case (grp)
      3'h0:    o_literal = i_word[15:0];
      3'h4:    o_literal = i_word[19:4];
      3'h5:    o_literal = {11'h000, i_word[4:0]};
      3'h7:    o_literal = {10'h000, i_word[9:4]};
      default: o_literal = 16'h0000;
    endcase
  end
endmodule // iwd_field_extract

// *** iwd_pkg.sv ***
// Types and shared decode functions of the instruction word decoder.
package iwd_pkg;
  `include "iwd_defines.svh"

  typedef enum logic [2:0] {
    IWD_CLS_CTRL = 3'h0,
    IWD_CLS_WORD = 3'h1,
    IWD_CLS_BIT  = 3'h2,
    IWD_CLS_LIT  = 3'h3,
    IWD_CLS_DSP  = 3'h4,
    IWD_CLS_NOP  = 3'h5
  } iwd_class_t;

  // Gray codes: every transition changes one bit.
  typedef enum logic [1:0] {
    IWD_ST_EXEC   = 2'h0,
    IWD_ST_SECOND = 2'h1,
    IWD_ST_BUBBLE = 2'h2
  } iwd_state_t;

  function automatic logic iwd_is_double(input logic [7:0] opc);
    return (opc == `IWD_OPC_DW_GOTO) || (opc == `IWD_OPC_DW_CALL) ||
           (opc == `IWD_OPC_DW_MOVD);
  endfunction

  function automatic iwd_class_t iwd_classify(input logic [7:0] opc);
    if (opc == `IWD_OPC_NOP) return IWD_CLS_NOP;
    case (opc[7:5])
      3'h0:    return IWD_CLS_CTRL;
      3'h1:    return IWD_CLS_WORD;
      3'h2:    return IWD_CLS_WORD;
      3'h3:    return IWD_CLS_BIT;
      3'h4:    return IWD_CLS_LIT;
      3'h5:    return IWD_CLS_LIT;
      default: return IWD_CLS_DSP;
    endcase
  endfunction
endpackage
